// [rtl/eee_c45_map.vh]
/*
  Constants for the energy efficient Ethernet register space: the management
  register numbers, indirect access function codes, device and index decode
  values, field positions and reset values.
  Assumes it is included by bare name from the design files under rtl/.
*/
// How it works
// - The whole space is reached only through management registers 13 and 14.
// - Delay registers at 1801, 1803, 1805, 1807 read zero while link down.
// - Status bit 11 latches transmit low power idle until the register is read.
// - Status bit 10 latches receive low power idle until the register is read.
// - Status bit 9 shows live transmit low power idle, never latched.
// - Status bit 8 shows live receive low power idle, never latched.
// - Status bit 2 shows live receive link; other status bits read zero.
// - Capability register is read-only: bit 2 gigabit, bit 1 100 Mb/s.
// - A 16-bit counter counts wake sequence faults, refresh or wakeup, and holds at FFFF.
// - Wake fault counter clears after a read of its own register and on hardware or software reset.
// - Advertisement contents are sent in the next page after the message code.
// - Advertisement bits 2 and 1 are read/write, reset zero; others read zero.
// - Partner advertisement is read-only; writes change nothing.
// - On negotiation complete, partner bits 2 and 1 come from the received page.
// - Device 1 gives four read-only PHY delay values at 1801 to 1807.
// - Device 4 gives four read-only serial interface delays at 1801 to 1807.
// - A dotted address means device number, then register index in that device.
`ifndef EEE_C45_MAP_VH
`define EEE_C45_MAP_VH

// Management register numbers of the indirect access pair.
`define EEE_MGMT_CTRL_REG 5'h0D
`define EEE_MGMT_DATA_REG 5'h0E

// Control register fields and function codes.
`define EEE_FUNC_HI 15
`define EEE_FUNC_LO 14
`define EEE_DEVAD_HI 4
`define EEE_DEVAD_LO 0
`define EEE_FUNC_ADDR 2'h0
`define EEE_FUNC_DATA 2'h1
`define EEE_FUNC_INC_RW 2'h2
`define EEE_FUNC_INC_WR 2'h3

// Device numbers.
`define EEE_DEV_PMA 5'h01
`define EEE_DEV_PCS 5'h03
`define EEE_DEV_SIF 5'h04
`define EEE_DEV_AN 5'h07

// Register indices within a device.
`define EEE_IDX_TX_MAX 16'h0709
`define EEE_IDX_TX_MIN 16'h070B
`define EEE_IDX_RX_MAX 16'h070D
`define EEE_IDX_RX_MIN 16'h070F
`define EEE_IDX_PCS_STATUS 16'h0001
`define EEE_IDX_CAPABILITY 16'h0014
`define EEE_IDX_WAKE_COUNT 16'h0016
`define EEE_IDX_LOCAL_ADV 16'h003C
`define EEE_IDX_PARTNER_ADV 16'h003D

// Field positions.
`define EEE_BIT_TX_LPI_LATCH 11
`define EEE_BIT_RX_LPI_LATCH 10
`define EEE_BIT_TX_LPI_NOW 9
`define EEE_BIT_RX_LPI_NOW 8
`define EEE_BIT_LINK 2
`define EEE_BIT_GIG 2
`define EEE_BIT_100 1

// Reset values and limits.
`define EEE_RESET_WORD 16'h0000
`define EEE_RESET_FIELD2 2'h0
`define EEE_COUNT_MAX 16'hFFFF

`endif

// [rtl/eee_latch_high.v]
/*
  Latch-high status bit: holds a one seen on the live input until a read
  clears it, after which it follows the live condition again.
  Assumes live and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module eee_latch_high
(
  input wire ref_clk,
  input wire reset,
  input wire live,
  input wire clear,
  output reg latched_q
);

  // A new event in the clearing cycle survives the clear.
  always @(posedge ref_clk)
  begin
    if (reset)
      latched_q <= 1'b0;
    else
      latched_q <= live | (latched_q & ~clear);
  end

endmodule // eee_latch_high
`default_nettype wire

// [rtl/eee_wake_counter.v]
/*
  Saturating 16-bit wake fault counter, cleared by a read and by resets.
  Assumes fault is a one-cycle pulse from the low power idle logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eee_c45_map.vh"
module eee_wake_counter
(
  input wire ref_clk,
  input wire reset,
  input wire soft_reset,
  input wire fault,
  input wire clear,
  output reg [15:0] count_q
);

  reg [15:0] base;
  reg [15:0] count_d;

  // Clear first, then count, so a fault in the read cycle is kept.
  always @*
  begin
    base = clear ? `EEE_RESET_WORD : count_q;
    count_d = base;
    if (fault && (base != `EEE_COUNT_MAX))
      count_d = base + 16'h0001;
  end

  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
      count_q <= `EEE_RESET_WORD;
    else
      count_q <= count_d;
  end

endmodule // eee_wake_counter
`default_nettype wire

// [rtl/eee_c45_regs.v]
/*
  Per-port energy efficient Ethernet register space behind the indirect
  access pair of the management register set: PCS low power status,
  capability, wake fault counter, local and partner advertisement and the
  read-only latency values of the PHY and serial interface.
  Assumes the management front end delivers one-cycle read and write strobes
  for management registers on ref_clk, and that all status inputs come from
  logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eee_c45_map.vh"
module eee_c45_regs
#(
  parameter CAP_GIG = 1'b1,
  parameter CAP_100 = 1'b1
)
(
  input wire ref_clk,
  input wire reset,
  input wire soft_reset,
  input wire [4:0] mgmt_addr,
  input wire mgmt_wr,
  input wire mgmt_rd,
  input wire [15:0] mgmt_wdata,
  output reg [15:0] mgmt_rdata_q,
  output reg mgmt_rvalid_q,
  input wire link_up,
  input wire tx_lpi_now,
  input wire rx_lpi_now,
  input wire wake_fault,
  input wire an_complete,
  input wire [15:0] lp_page,
  input wire [15:0] phy_tx_max_latency,
  input wire [15:0] phy_tx_min_latency,
  input wire [15:0] phy_rx_max_latency,
  input wire [15:0] phy_rx_min_latency,
  input wire [15:0] serial_if_tx_max_latency,
  input wire [15:0] serial_if_tx_min_latency,
  input wire [15:0] serial_if_rx_max_latency,
  input wire [15:0] serial_if_rx_min_latency,
  output reg [15:0] adv_page_q
);

  // Indirect access state: function, device number and register index.
  reg [1:0] func_q;
  reg [4:0] devad_q;
  reg [15:0] idx_q;
  reg [15:0] idx_d;

  // Stored advertisement fields.
  reg [1:0] local_adv_q;
  reg [1:0] partner_adv_q;

  // Read mux result and decode flags.
  reg [15:0] c45_rdata;
  reg [15:0] rd_word;
  reg is_delay_idx;

  wire sel_ctrl;
  wire sel_data;
  wire wr_ctrl;
  wire wr_data;
  wire rd_data;
  wire is_data_func;
  wire data_wr;
  wire data_rd;
  wire status_read;
  wire count_read;
  wire [1:0] lpi_live;
  wire [1:0] lpi_latched;
  wire [15:0] wake_count;
  wire [1:0] cap_field;

  // Strobe decode; a write in the same cycle as a read wins and the read is dropped.
  // indirect pair decode
  assign sel_ctrl = (mgmt_addr == `EEE_MGMT_CTRL_REG);
  assign sel_data = (mgmt_addr == `EEE_MGMT_DATA_REG);
  assign wr_ctrl = mgmt_wr & sel_ctrl;
  assign wr_data = mgmt_wr & sel_data;
  assign rd_data = mgmt_rd & ~mgmt_wr & sel_data;

  // Data register accesses reach the space only under a data function.
  // function selects data
  assign is_data_func = (func_q != `EEE_FUNC_ADDR);
  assign data_wr = wr_data & is_data_func;
  assign data_rd = rd_data & is_data_func;

  // Read side effects of the status and counter registers.
  assign status_read = data_rd && (devad_q == `EEE_DEV_PCS) &&
                       (idx_q == `EEE_IDX_PCS_STATUS);
  assign count_read = data_rd && (devad_q == `EEE_DEV_PCS) &&
                      (idx_q == `EEE_IDX_WAKE_COUNT);

  // Capability is fixed at build time.
  assign cap_field = {CAP_GIG, CAP_100};

  // Live idle conditions, transmit in the upper position.
  assign lpi_live = {tx_lpi_now, rx_lpi_now};

  // One latch-high cell for each of the transmit and receive idle bits.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_lpi_latch
      eee_latch_high u_latch
      (
        .ref_clk(ref_clk),
        .reset(reset | soft_reset),
        .live(lpi_live[gi]),
        .clear(status_read),
        .latched_q(lpi_latched[gi])
      );
    end
  endgenerate

  // Wake fault counter, cleared by its own read.
  eee_wake_counter u_wake
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .soft_reset(soft_reset),
    .fault(wake_fault),
    .clear(count_read),
    .count_q(wake_count)
  );

  // Index update: address writes load it, post-increment functions advance it.
  always @*
  begin
    idx_d = idx_q;
    if (wr_data && (func_q == `EEE_FUNC_ADDR))
      idx_d = mgmt_wdata;
    else if ((func_q == `EEE_FUNC_INC_RW) && (data_rd || data_wr))
      idx_d = idx_q + 16'h0001;
    else if ((func_q == `EEE_FUNC_INC_WR) && data_wr)
      idx_d = idx_q + 16'h0001;
  end

  // Control and index registers of the indirect pair.
  // device then index
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
    begin
      func_q <= `EEE_FUNC_ADDR;
      devad_q <= 5'h00;
      idx_q <= `EEE_RESET_WORD;
    end
    else
    begin
      if (wr_ctrl)
      begin
        func_q <= mgmt_wdata[`EEE_FUNC_HI:`EEE_FUNC_LO];
        devad_q <= mgmt_wdata[`EEE_DEVAD_HI:`EEE_DEVAD_LO];
      end
      idx_q <= idx_d;
    end
  end

  // Local advertisement: only bits 2 and 1 are writable.
  // writable advert bits
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
      local_adv_q <= `EEE_RESET_FIELD2;
    else if (data_wr && (devad_q == `EEE_DEV_AN) && (idx_q == `EEE_IDX_LOCAL_ADV))
      local_adv_q <= {mgmt_wdata[`EEE_BIT_GIG], mgmt_wdata[`EEE_BIT_100]};
  end

  // Partner advertisement is loaded only from the received next page.
  // capture partner page
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
      partner_adv_q <= `EEE_RESET_FIELD2;
    else if (an_complete)
      partner_adv_q <= {lp_page[`EEE_BIT_GIG], lp_page[`EEE_BIT_100]};
  end

  // Outgoing next page body mirrors the local advertisement.
  // advert into page
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
      adv_page_q <= `EEE_RESET_WORD;
    else
    begin
      adv_page_q <= `EEE_RESET_WORD;
      adv_page_q[`EEE_BIT_GIG] <= local_adv_q[1];
      adv_page_q[`EEE_BIT_100] <= local_adv_q[0];
    end
  end

  // Read multiplexer of the register space.
  always @*
  begin
    c45_rdata = `EEE_RESET_WORD;
    is_delay_idx = (idx_q == `EEE_IDX_TX_MAX) || (idx_q == `EEE_IDX_TX_MIN) ||
                   (idx_q == `EEE_IDX_RX_MAX) || (idx_q == `EEE_IDX_RX_MIN);
    case (devad_q)
      `EEE_DEV_PMA:
      begin
        case (idx_q)
          `EEE_IDX_TX_MAX: c45_rdata = phy_tx_max_latency;
          `EEE_IDX_TX_MIN: c45_rdata = phy_tx_min_latency;
          `EEE_IDX_RX_MAX: c45_rdata = phy_rx_max_latency;
          `EEE_IDX_RX_MIN: c45_rdata = phy_rx_min_latency;
          default: c45_rdata = `EEE_RESET_WORD;
        endcase
      end
      `EEE_DEV_SIF:
      begin
        case (idx_q)
          `EEE_IDX_TX_MAX: c45_rdata = serial_if_tx_max_latency;
          `EEE_IDX_TX_MIN: c45_rdata = serial_if_tx_min_latency;
          `EEE_IDX_RX_MAX: c45_rdata = serial_if_rx_max_latency;
          `EEE_IDX_RX_MIN: c45_rdata = serial_if_rx_min_latency;
          default: c45_rdata = `EEE_RESET_WORD;
        endcase
      end
      `EEE_DEV_PCS:
      begin
        case (idx_q)
          `EEE_IDX_PCS_STATUS:
          begin
            c45_rdata[`EEE_BIT_TX_LPI_LATCH] = lpi_latched[1] | tx_lpi_now; // Idle seen now counts.
            c45_rdata[`EEE_BIT_RX_LPI_LATCH] = lpi_latched[0] | rx_lpi_now;
            c45_rdata[`EEE_BIT_TX_LPI_NOW] = tx_lpi_now;
            c45_rdata[`EEE_BIT_RX_LPI_NOW] = rx_lpi_now;
            c45_rdata[`EEE_BIT_LINK] = link_up;
          end
          `EEE_IDX_CAPABILITY:
          begin
            c45_rdata[`EEE_BIT_GIG] = cap_field[1];
            c45_rdata[`EEE_BIT_100] = cap_field[0];
          end
          `EEE_IDX_WAKE_COUNT: c45_rdata = wake_count;
          default: c45_rdata = `EEE_RESET_WORD;
        endcase
      end
      `EEE_DEV_AN:
      begin
        case (idx_q)
          `EEE_IDX_LOCAL_ADV:
          begin
            c45_rdata[`EEE_BIT_GIG] = local_adv_q[1];
            c45_rdata[`EEE_BIT_100] = local_adv_q[0];
          end
          `EEE_IDX_PARTNER_ADV:
          begin
            c45_rdata[`EEE_BIT_GIG] = partner_adv_q[1];
            c45_rdata[`EEE_BIT_100] = partner_adv_q[0];
          end
          default: c45_rdata = `EEE_RESET_WORD;
        endcase
      end
      default: c45_rdata = `EEE_RESET_WORD;
    endcase
    if (!link_up && is_delay_idx)
      c45_rdata = `EEE_RESET_WORD;
  end

  // Word returned for a management read of the pair.
  always @*
  begin
    rd_word = `EEE_RESET_WORD;
    if (sel_ctrl)
    begin
      rd_word[`EEE_FUNC_HI:`EEE_FUNC_LO] = func_q;
      rd_word[`EEE_DEVAD_HI:`EEE_DEVAD_LO] = devad_q;
    end
    else if (sel_data)
      rd_word = is_data_func ? c45_rdata : idx_q;
  end

  // Read answer is registered and valid one cycle after the strobe.
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
    begin
      mgmt_rdata_q <= `EEE_RESET_WORD;
      mgmt_rvalid_q <= 1'b0;
    end
    else
    begin
      mgmt_rvalid_q <= mgmt_rd & ~mgmt_wr;
      if (mgmt_rd && !mgmt_wr)
        mgmt_rdata_q <= rd_word;
    end
  end

endmodule // eee_c45_regs
`default_nettype wire

// [rtl/unused_placeholder_note.v]
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [testbench/eee_c45_regs_chk.sv]
/*
  Port checker for the energy efficient Ethernet register space.
  Assumes it is bound to eee_c45_regs and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module eee_c45_regs_chk
#(
  parameter CAP_GIG = 1'b1,
  parameter CAP_100 = 1'b1
)
(
  input wire ref_clk,
  input wire reset,
  input wire soft_reset,
  input wire [4:0] mgmt_addr,
  input wire mgmt_wr,
  input wire mgmt_rd,
  input wire [15:0] mgmt_wdata,
  input wire [15:0] mgmt_rdata_q,
  input wire mgmt_rvalid_q,
  input wire link_up,
  input wire tx_lpi_now,
  input wire rx_lpi_now,
  input wire [15:0] adv_page_q
);
  logic [1:0] fn_q;
  logic [4:0] dev_q;
  logic [15:0] idx_q;
  logic dat_rd;
  logic dat_wr;
  logic dly;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || soft_reset);
  // Strobes that hit the data register under a data function.
  assign dat_rd = mgmt_rd && !mgmt_wr && mgmt_addr == 5'h0E && fn_q != 2'h0;
  assign dat_wr = mgmt_wr && mgmt_addr == 5'h0E && fn_q != 2'h0;
  assign dly = (dev_q == 5'h01 || dev_q == 5'h04) && idx_q[15:4] == 12'h070 && idx_q[0];
  // Shadow of the indirect pointer, so each read is tied to its target.
  always @(posedge ref_clk)
  begin
    if (reset || soft_reset)
      {fn_q, dev_q, idx_q} <= 23'h000000;
    else if (mgmt_wr && mgmt_addr == 5'h0D)
      {fn_q, dev_q} <= {mgmt_wdata[15:14], mgmt_wdata[4:0]};
    else if (mgmt_wr && mgmt_addr == 5'h0E && fn_q == 2'h0)
      idx_q <= mgmt_wdata;
    else if ((dat_rd && fn_q == 2'h2) || (dat_wr && fn_q[1]))
      idx_q <= idx_q + 16'h0001;
  end
  sequence s_rd(logic [4:0] d, logic [15:0] i);
    dat_rd && dev_q == d && idx_q == i;
  endsequence
  sequence s_adv_wr;
    dat_wr && dev_q == 5'h07 && idx_q == 16'h003C;
  endsequence
  a_read_answer: assert property (mgmt_rd && !mgmt_wr |=> mgmt_rvalid_q)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (mgmt_rvalid_q |-> $past(mgmt_rd && !mgmt_wr))
    else $error("answer without a lone read strobe");
  a_delay_down: assert property (dat_rd && dly && !link_up |=> mgmt_rdata_q == 16'h0000)
    else $error("delay value read while link down");
  a_cap_value: assert property (s_rd(5'h03, 16'h0014) |=>
    mgmt_rdata_q == {13'h0000, CAP_GIG, CAP_100, 1'b0})
    else $error("capability word wrong");
  a_status_live: assert property (s_rd(5'h03, 16'h0001) |=>
    mgmt_rdata_q[9:8] == $past({tx_lpi_now, rx_lpi_now}) && mgmt_rdata_q[2] == $past(link_up))
    else $error("live status bits wrong");
  a_status_rsvd: assert property (s_rd(5'h03, 16'h0001) |=>
    mgmt_rdata_q[15:12] == 4'h0 && mgmt_rdata_q[7:3] == 5'h00 && mgmt_rdata_q[1:0] == 2'h0)
    else $error("status reserved bits not zero");
  a_latch_live: assert property (s_rd(5'h03, 16'h0001) |=>
    (mgmt_rdata_q[11:10] & $past({tx_lpi_now, rx_lpi_now})) == $past({tx_lpi_now, rx_lpi_now}))
    else $error("latched bit missed a live event");
  a_adv_page: assert property (s_adv_wr |=> ##1
    adv_page_q == {13'h0000, $past(mgmt_wdata[2:1], 2), 1'b0})
    else $error("page out did not follow the advert write");
  a_adv_rsvd: assert property (adv_page_q[15:3] == 13'h0000 && !adv_page_q[0])
    else $error("page out reserved bits set");
endmodule // eee_c45_regs_chk
`default_nettype wire

// [testbench/eee_host_model.sv]
/*
  Station management host model driving the management register pair.
  Assumes one-cycle strobes and a registered read answer one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none
module eee_host_model
(
  input wire ref_clk,
  output logic [4:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input wire [15:0] mgmt_rdata_q,
  input wire mgmt_rvalid_q
);
  logic slow;
  // Idle bus at time zero.
  initial
  begin
    {mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata} = 23'h000000;
  end
  // One strobe cycle; data is inverted once released so stale values never linger.
  // Any management register
  task automatic acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic v);
    @(posedge ref_clk);
    if (slow)
      repeat (3) @(posedge ref_clk);
    mgmt_addr <= a;
    mgmt_wr <= w;
    mgmt_rd <= r;
    mgmt_wdata <= d;
    @(posedge ref_clk);
    mgmt_wr <= 1'b0;
    mgmt_rd <= 1'b0;
    mgmt_wdata <= ~d;
    #1;
    q = mgmt_rdata_q;
    v = mgmt_rvalid_q;
  endtask
  // Full indirect access: device, index, data function, then data.
  // Device then index
  task automatic c45(input logic w, input logic [4:0] dv, input logic [15:0] ix,
                     input logic [15:0] d, output logic [15:0] q, output logic v);
    acc(1'b1, 1'b0, 5'h0D, {11'h000, dv}, q, v);
    acc(1'b1, 1'b0, 5'h0E, ix, q, v);
    acc(1'b1, 1'b0, 5'h0D, {11'h200, dv}, q, v);
    acc(w, !w, 5'h0E, d, q, v);
  endtask
endmodule // eee_host_model
`default_nettype wire

// [testbench/tb.sv]
/*
  Self-checking bench for the register space with a host model and checker.
  Assumes the design sources and headers under rtl/ are on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam CAP_GIG = 1'b1;
  localparam CAP_100 = 1'b0;
  logic ref_clk, reset, soft_reset, link_up, tx_lpi_now, rx_lpi_now, wake_fault, an_complete;
  logic mgmt_wr, mgmt_rd, mgmt_rvalid_q, v;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata_q, adv_page_q, lp_page, q, e, n;
  logic [15:0] lat [0:7];
  logic [31:0] seed;
  int n_fail, checked, i, k;
  eee_c45_regs #(.CAP_GIG(CAP_GIG), .CAP_100(CAP_100)) u_dut (.ref_clk(ref_clk),
    .reset(reset), .soft_reset(soft_reset), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_q(mgmt_rdata_q),
    .mgmt_rvalid_q(mgmt_rvalid_q), .link_up(link_up), .tx_lpi_now(tx_lpi_now),
    .rx_lpi_now(rx_lpi_now), .wake_fault(wake_fault), .an_complete(an_complete),
    .lp_page(lp_page), .phy_tx_max_latency(lat[0]), .phy_tx_min_latency(lat[1]),
    .phy_rx_max_latency(lat[2]), .phy_rx_min_latency(lat[3]),
    .serial_if_tx_max_latency(lat[4]), .serial_if_tx_min_latency(lat[5]),
    .serial_if_rx_max_latency(lat[6]), .serial_if_rx_min_latency(lat[7]),
    .adv_page_q(adv_page_q));
  eee_host_model u_host (.ref_clk(ref_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_q(mgmt_rdata_q),
    .mgmt_rvalid_q(mgmt_rvalid_q));
  // Clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected advert word: only bits 2 and 1 carry meaning, the rest read zero.
  function automatic logic [15:0] adv_bits(input logic [15:0] w);
    adv_bits = {13'h0000, w[2:1], 1'b0};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cr(input logic [4:0] dv, input logic [15:0] ix, input logic [15:0] ex);
    u_host.c45(1'b0, dv, ix, 16'h0000, q, v);
    chk({15'h0000, v}, 16'h0001);
    chk(q, ex);
  endtask
  task automatic cw(input logic [4:0] dv, input logic [15:0] ix, input logic [15:0] d);
    u_host.c45(1'b1, dv, ix, d, q, v);
  endtask
  task automatic summarize;
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short well after the sequence should have ended.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
  // Main sequence of scenarios.
  initial
  begin
    ref_clk = 1'b0;
    seed = 32'h643B;
    u_host.slow = 1'b0;
    {reset, soft_reset, link_up, tx_lpi_now, rx_lpi_now, wake_fault, an_complete} = 7'h40;
    lp_page = 16'h0000;
    for (i = 0; i < 8; i++)
      lat[i] = 16'h0000;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    cr(5'h07, 16'h003C, 16'h0000);
    cr(5'h07, 16'h003D, 16'h0000);
    cr(5'h03, 16'h0016, 16'h0000);
    cw(5'h03, 16'h0014, 16'hFFFF);
    cr(5'h03, 16'h0014, {13'h0000, CAP_GIG, CAP_100, 1'b0});
    for (i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      lat[i] <= seed[15:0];
    end
    for (k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      link_up <= (k == 0);
      u_host.slow = (k == 1);
      for (i = 0; i < 8; i++)
        cr(i < 4 ? 5'h01 : 5'h04, {12'h070, 1'b1, i[1:0], 1'b1}, k ? 16'h0000 : lat[i]);
    end
    u_host.slow = 1'b0;
    @(posedge ref_clk);
    link_up <= 1'b1;
    tx_lpi_now <= 1'b1;
    @(posedge ref_clk);
    tx_lpi_now <= 1'b0;
    rx_lpi_now <= 1'b1;
    cr(5'h03, 16'h0001, 16'h0D04);
    @(posedge ref_clk);
    rx_lpi_now <= 1'b0;
    cr(5'h03, 16'h0001, 16'h0404);
    link_up <= 1'b0;
    cr(5'h03, 16'h0001, 16'h0000);
    seed = lfsr(seed);
    e = seed[15:0];
    cw(5'h07, 16'h003C, e);
    cr(5'h07, 16'h003C, adv_bits(e));
    chk(adv_page_q, adv_bits(e));
    seed = lfsr(seed);
    @(posedge ref_clk);
    lp_page <= seed[15:0];
    an_complete <= 1'b1;
    @(posedge ref_clk);
    an_complete <= 1'b0;
    cr(5'h07, 16'h003D, adv_bits(seed[15:0]));
    cw(5'h07, 16'h003D, ~seed[15:0]);
    cr(5'h07, 16'h003D, adv_bits(seed[15:0]));
    // Post-increment functions walk the index across the advert pair.
    u_host.acc(1'b1, 1'b0, 5'h0D, 16'h0007, q, v);
    u_host.acc(1'b1, 1'b0, 5'h0E, 16'h003C, q, v);
    u_host.acc(1'b1, 1'b0, 5'h0D, 16'h8007, q, v);
    u_host.acc(1'b0, 1'b1, 5'h0E, 16'h0000, q, v);
    chk(q, adv_bits(e));
    u_host.acc(1'b0, 1'b1, 5'h0E, 16'h0000, q, v);
    chk(q, adv_bits(seed[15:0]));
    u_host.acc(1'b1, 1'b0, 5'h0D, 16'hC007, q, v);
    u_host.acc(1'b0, 1'b1, 5'h0D, 16'h0000, q, v);
    chk(q, 16'hC007);
    u_host.acc(1'b0, 1'b1, 5'h0E, 16'h0000, q, v);
    chk(q, 16'h0000);
    u_host.acc(1'b1, 1'b0, 5'h0E, 16'h0000, q, v);
    u_host.acc(1'b1, 1'b0, 5'h0D, 16'h0007, q, v);
    u_host.acc(1'b0, 1'b1, 5'h0E, 16'h0000, q, v);
    chk(q, 16'h003F);
    n = {12'h000, seed[19:16]} + 16'h0002;
    repeat (n)
    begin
      @(posedge ref_clk);
      wake_fault <= 1'b1;
      @(posedge ref_clk);
      wake_fault <= 1'b0;
    end
    cr(5'h03, 16'h0016, n);
    cr(5'h03, 16'h0016, 16'h0000);
    u_host.acc(1'b1, 1'b1, 5'h0E, 16'h0000, q, v);
    chk({15'h0000, v}, 16'h0000);
    u_host.acc(1'b0, 1'b1, 5'h05, 16'h0000, q, v);
    chk(q, 16'h0000);
    u_host.acc(1'b1, 1'b0, 5'h0D, 16'h0003, q, v);
    u_host.acc(1'b0, 1'b1, 5'h0E, 16'h0000, q, v);
    chk(q, 16'h0016);
    @(posedge ref_clk);
    wake_fault <= 1'b1;
    @(posedge ref_clk);
    wake_fault <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    cr(5'h03, 16'h0016, 16'h0000);
    cr(5'h07, 16'h003C, 16'h0000);
    summarize();
  end
endmodule // tb
bind eee_c45_regs eee_c45_regs_chk #(.CAP_GIG(CAP_GIG), .CAP_100(CAP_100)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .soft_reset(soft_reset), .mgmt_addr(mgmt_addr),
  .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q), .link_up(link_up),
  .tx_lpi_now(tx_lpi_now), .rx_lpi_now(rx_lpi_now), .adv_page_q(adv_page_q));
`default_nettype wire
